// ---- rtl/ssr_pkg.sv ----
// package of constants, commands and carriers for the status service request unit
package ssr_pkg;

  // ---------------------------------------------------------------
  // widths and field positions
  // ---------------------------------------------------------------
  localparam int unsigned REG_W       = 8;
  localparam int unsigned MSS_BIT     = 6;
  localparam int unsigned ESB_BIT     = 5;
  localparam int unsigned OPC_BIT     = 0;

  // ---------------------------------------------------------------
  // reset values and fixed answers
  // ---------------------------------------------------------------
  localparam logic [7:0]  SRE_RST     = 8'h00;
  localparam logic [7:0]  ESE_RST     = 8'h00;
  localparam logic [7:0]  EVT_RST     = 8'h00;
  localparam logic [7:0]  RESP_RST    = 8'h00;
  localparam logic [7:0]  SET_RST     = 8'h00;
  localparam logic [7:0]  TST_PASS    = 8'h00;
  localparam logic [7:0]  OPC_ANSWER  = 8'h01;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_NS      = 5;
  localparam int unsigned TST_NS      = 40;
  localparam int unsigned TST_CYC     = (TST_NS + CLK_NS - 1) / CLK_NS;

  // ---------------------------------------------------------------
  // command codes
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    SSR_CMD_NOP   = 4'h0,
    SSR_CMD_RST   = 4'h1,
    SSR_CMD_CLS   = 4'h2,
    SSR_CMD_SRE   = 4'h3,
    SSR_CMD_SREQ  = 4'h4,
    SSR_CMD_STBQ  = 4'h5,
    SSR_CMD_TSTQ  = 4'h6,
    SSR_CMD_WAI   = 4'h7,
    SSR_CMD_OPC   = 4'h8,
    SSR_CMD_OPCQ  = 4'h9,
    SSR_CMD_ESE   = 4'hA,
    SSR_CMD_ESEQ  = 4'hB,
    SSR_CMD_ESRQ  = 4'hC,
    SSR_CMD_SEQ   = 4'hD,
    SSR_CMD_OVL   = 4'hE,
    SSR_CMD_SET   = 4'hF
  } ssr_cmd_e;

  // command word from the controller
  typedef struct packed {
    ssr_cmd_e   op;
    logic [7:0] arg;
  } ssr_cmd_s;

  // response word back to the controller
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } ssr_resp_s;

  // ---------------------------------------------------------------
  // shared functions
  // ---------------------------------------------------------------
  function automatic logic [7:0] ssr_rise(input logic [7:0] now, input logic [7:0] was);
    ssr_rise = now & ~was;
  endfunction

endpackage

// ---- rtl/ssr_self_test.sv ----
// main board self test sequencer
`timescale 1ns/1ps
`default_nettype none
module ssr_self_test
  import ssr_pkg::*;
#(
  parameter int unsigned CYC = TST_CYC
)(
  // clocking
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  // control
  input  wire logic       start,
  input  wire logic       board_fault,
  // result
  output logic            done,
  output logic [7:0]      result
);

  logic [7:0] cnt;
  logic       busy;
  logic       fault;
  logic [7:0] next_cnt;
  logic       next_busy;
  logic       next_fault;
  logic       next_done;
  logic [7:0] next_result;

  always_comb begin
    next_cnt    = cnt;
    next_busy   = busy;
    next_fault  = fault;
    next_done   = 1'b0;
    next_result = result;
    if (start && !busy) begin
      next_busy  = 1'b1;
      next_cnt   = 8'(CYC - 1);
      next_fault = 1'b0;
    end else if (busy) begin
      next_fault = fault | board_fault;
      if (cnt == 8'h00) begin
        next_busy   = 1'b0;
        next_done   = 1'b1;
        // zero means the board passed
        next_result = (fault | board_fault) ? 8'h01 : TST_PASS;
      end else begin
        next_cnt = cnt - 8'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt    <= 8'h00;
      busy   <= 1'b0;
      fault  <= 1'b0;
      done   <= 1'b0;
      result <= TST_PASS;
    end else if (ce) begin
      cnt    <= next_cnt;
      busy   <= next_busy;
      fault  <= next_fault;
      done   <= next_done;
      result <= next_result;
    end
  end

endmodule
`default_nettype wire

// ---- rtl/ssr_srq_gen.sv ----
// service request edge detector over the status byte and its mask
`timescale 1ns/1ps
`default_nettype none
module ssr_srq_gen
  import ssr_pkg::*;
(
  // clocking
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  // status and mask
  input  wire logic [7:0] stb_low,
  input  wire logic [7:0] mask,
  // request pulse
  output logic            srq
);

  logic [7:0] stb_prev;
  logic [7:0] mask_prev;
  logic [7:0] next_stb_prev;
  logic [7:0] next_mask_prev;
  logic       next_srq;

  always_comb begin
    next_stb_prev  = stb_low;
    next_mask_prev = mask;
    // either edge counts while the other side is already set
    next_srq = |(ssr_rise(stb_low, stb_prev) & mask)
             | |(ssr_rise(mask, mask_prev) & stb_low);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      stb_prev  <= 8'h00;
      mask_prev <= 8'h00;
      srq       <= 1'b0;
    end else if (ce) begin
      stb_prev  <= next_stb_prev;
      mask_prev <= next_mask_prev;
      srq       <= next_srq;
    end
  end

endmodule
`default_nettype wire

// ---- rtl/ssr_top.sv ----
// status byte, service request and common command core
// What this block does
// - device reset presets all settings and cancels pending completion requests
// - device reset keeps error queue, enable and transition registers
// - service request mask accepts any value 0 to 255
// - bit 6 of the written mask is ignored
// - status bit rising while enabled raises a service request
// - mask bit rising while status bit set raises a service request
// - mask query returns the current mask
// - status byte read returns all eight bits and changes nothing
// - only clear status, the event register query and the enable register writes clear status byte bits
// - self test returns zero on pass, non zero on fault
// - wait holds later commands until overlapped work completes
// - sequential commands block; overlapped commands let later ones start
// - enabled standard event summary drives status bit 5
// - clear status empties errors, zeroes events, keeps enables
// - idle overlap flag is low while overlapped work is pending
`timescale 1ns/1ps
`default_nettype none
module ssr_top
  import ssr_pkg::*;
#(
  parameter int unsigned SEQ_CYC = 4,
  parameter int unsigned OVL_CYC = 16
)(
  // clocking
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  // command port
  input  wire logic       cmd_valid,
  input  wire ssr_cmd_s   cmd,
  output logic            cmd_ready,
  // response port
  output ssr_resp_s       resp,
  // status sources from the rest of the module
  input  wire logic [4:0] stb_src,
  input  wire logic       err_nonempty,
  input  wire logic [7:0] evt_set,
  input  wire logic       board_fault,
  // effects on the rest of the module
  output logic            err_clear,
  output logic [7:0]      setting,
  output logic            srq
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SEQ  = 4'b0010,
    ST_WAIT = 4'b0100,
    ST_TST  = 4'b1000
  } ssr_st_e;

  ssr_st_e    st;
  ssr_st_e    next_st;
  logic [7:0] sre;
  logic [7:0] next_sre;
  logic [7:0] ese;
  logic [7:0] next_ese;
  logic [7:0] esr;
  logic [7:0] next_esr;
  logic [7:0] setting_q;
  logic [7:0] next_setting;
  logic [7:0] seq_cnt;
  logic [7:0] next_seq_cnt;
  logic [7:0] ovl_cnt;
  logic [7:0] next_ovl_cnt;
  logic       opc_cmd;
  logic       next_opc_cmd;
  logic       opc_qry;
  logic       next_opc_qry;
  ssr_resp_s  next_resp;
  logic       next_err_clear;
  logic       idle_overlap_flag;
  logic       tst_start;
  logic       tst_done;
  logic [7:0] tst_result;
  logic [7:0] stb_low;
  logic [7:0] stb;
  logic       take;

  // ---------------------------------------------------------------
  // status byte
  // ---------------------------------------------------------------
  // the pending error count lives outside; bit 2 reports it non empty
  always_comb begin
    stb_low          = 8'h00;
    stb_low[1:0]     = stb_src[1:0];
    stb_low[2]       = err_nonempty;
    stb_low[4:3]     = stb_src[3:2];
    stb_low[ESB_BIT] = |(esr & ese);
    stb_low[7]       = stb_src[4];
    stb              = stb_low;
    stb[MSS_BIT]     = |(stb_low & sre & ~(8'h01 << MSS_BIT));
  end

  assign idle_overlap_flag = (ovl_cnt == 8'h00);
  assign take      = cmd_valid && cmd_ready;
  assign cmd_ready = (st == ST_IDLE);
  assign tst_start = take && (cmd.op == SSR_CMD_TSTQ);
  assign setting   = setting_q;

  // ---------------------------------------------------------------
  // command sequencer
  // ---------------------------------------------------------------
  always_comb begin
    next_st        = st;
    next_sre       = sre;
    next_ese       = ese;
    next_esr       = esr | evt_set;
    next_setting   = setting_q;
    next_seq_cnt   = seq_cnt;
    next_ovl_cnt   = (ovl_cnt != 8'h00) ? ovl_cnt - 8'h01 : 8'h00;
    next_opc_cmd   = opc_cmd;
    next_opc_qry   = opc_qry;
    next_resp      = '{valid: 1'b0, data: resp.data};
    next_err_clear = 1'b0;
    case (st)
      ST_IDLE: begin
        if (take) begin
          case (cmd.op)
            SSR_CMD_RST: begin
              // enables, error queue and transitions are left alone
              next_setting = SET_RST;
              next_opc_cmd = 1'b0;
              next_opc_qry = 1'b0;
              next_resp.valid = 1'b0;
            end
            SSR_CMD_CLS: begin
              // event sources asserting now still land: set wins
              next_esr       = evt_set;
              next_err_clear = 1'b1;
              next_opc_cmd   = 1'b0;
              next_opc_qry   = 1'b0;
              next_resp.valid = 1'b0;
            end
            SSR_CMD_SRE: begin
              next_sre = cmd.arg & ~(8'h01 << MSS_BIT);
            end
            SSR_CMD_SREQ: next_resp = '{valid: 1'b1, data: sre};
            SSR_CMD_STBQ: next_resp = '{valid: 1'b1, data: stb};
            SSR_CMD_ESE:  next_ese  = cmd.arg;
            SSR_CMD_ESEQ: next_resp = '{valid: 1'b1, data: ese};
            SSR_CMD_ESRQ: begin
              next_resp = '{valid: 1'b1, data: esr};
              next_esr  = evt_set;
            end
            SSR_CMD_OPC:  next_opc_cmd = 1'b1;
            SSR_CMD_OPCQ: next_opc_qry = 1'b1;
            SSR_CMD_TSTQ: next_st = ST_TST;
            SSR_CMD_WAI: begin
              if (!idle_overlap_flag) begin
                next_st = ST_WAIT;
              end
            end
            SSR_CMD_SEQ: begin
              next_st      = ST_SEQ;
              next_seq_cnt = 8'(SEQ_CYC - 1);
            end
            SSR_CMD_OVL: next_ovl_cnt = 8'(OVL_CYC);
            SSR_CMD_SET: next_setting = cmd.arg;
            default: next_st = ST_IDLE;
          endcase
        end
      end
      ST_SEQ: begin
        if (seq_cnt == 8'h00) begin
          next_st = ST_IDLE;
        end else begin
          next_seq_cnt = seq_cnt - 8'h01;
        end
      end
      ST_WAIT: begin
        if (idle_overlap_flag) begin
          next_st = ST_IDLE;
        end
      end
      ST_TST: begin
        if (tst_done) begin
          next_st   = ST_IDLE;
          next_resp = '{valid: 1'b1, data: tst_result};
        end
      end
      default: next_st = ST_IDLE;
    endcase
    // completion is resolved after decode so reset and clear can cancel it,
    // and a read-and-clear of the event register cannot swallow the set
    if (next_opc_cmd && idle_overlap_flag) begin
      next_esr[OPC_BIT] = 1'b1;
      next_opc_cmd      = 1'b0;
    end
    // the completion answer yields to any other answer due in this cycle
    if (next_opc_qry && idle_overlap_flag && !next_resp.valid) begin
      next_resp    = '{valid: 1'b1, data: OPC_ANSWER};
      next_opc_qry = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st        <= ST_IDLE;
      sre       <= SRE_RST;
      ese       <= ESE_RST;
      esr       <= EVT_RST;
      setting_q <= SET_RST;
      seq_cnt   <= 8'h00;
      ovl_cnt   <= 8'h00;
      opc_cmd   <= 1'b0;
      opc_qry   <= 1'b0;
      resp      <= '{valid: 1'b0, data: RESP_RST};
      err_clear <= 1'b0;
    end else if (ce) begin
      st        <= next_st;
      sre       <= next_sre;
      ese       <= next_ese;
      esr       <= next_esr;
      setting_q <= next_setting;
      seq_cnt   <= next_seq_cnt;
      ovl_cnt   <= next_ovl_cnt;
      opc_cmd   <= next_opc_cmd;
      opc_qry   <= next_opc_qry;
      resp      <= next_resp;
      err_clear <= next_err_clear;
    end
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  ssr_srq_gen u_srq (
    .clk     (clk),
    .rst     (rst),
    .ce      (ce),
    .stb_low (stb_low),
    .mask    (sre),
    .srq     (srq)
  );

  ssr_self_test u_tst (
    .clk         (clk),
    .rst         (rst),
    .ce          (ce),
    .start       (tst_start),
    .board_fault (board_fault),
    .done        (tst_done),
    .result      (tst_result)
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_rst_cmd;
    ce && take && cmd.op == SSR_CMD_RST;
  endsequence

  AST_RST_CANCEL: assert property (@(posedge clk) disable iff (rst)
    s_rst_cmd |=> !opc_cmd && !opc_qry)
    else $error("reset left a completion request pending");
  AST_RST_KEEP: assert property (@(posedge clk) disable iff (rst)
    s_rst_cmd |=> sre == $past(sre) && ese == $past(ese))
    else $error("reset changed an enable register");
  AST_SRE_BIT6: assert property (@(posedge clk) disable iff (rst)
    sre[MSS_BIT] == 1'b0)
    else $error("mask bit 6 stored");
  AST_SRE_WRITE: assert property (@(posedge clk) disable iff (rst)
    ce && take && cmd.op == SSR_CMD_SRE |=> sre == ($past(cmd.arg) & 8'hBF))
    else $error("mask write lost");
  AST_SRQ_STB: assert property (@(posedge clk) disable iff (rst)
    ce && $past(ce) && |(ssr_rise(stb_low, $past(stb_low)) & sre) |=> srq)
    else $error("status edge without request");
  AST_SRE_READ: assert property (@(posedge clk) disable iff (rst)
    ce && take && cmd.op == SSR_CMD_SREQ |=> resp.valid && resp.data == $past(sre))
    else $error("mask query wrong");
  AST_STB_READ: assert property (@(posedge clk) disable iff (rst)
    ce && take && cmd.op == SSR_CMD_STBQ |=>
      resp.data == $past(stb) && esr == ($past(esr) | $past(evt_set)))
    else $error("status read wrong or destructive");
  AST_WAIT_HOLD: assert property (@(posedge clk) disable iff (rst)
    st == ST_WAIT && !idle_overlap_flag |=> st == ST_WAIT && !cmd_ready)
    else $error("command taken during wait");
  AST_SEQ_BLOCK: assert property (@(posedge clk) disable iff (rst)
    ce && take && cmd.op == SSR_CMD_SEQ |=> !cmd_ready [*3])
    else $error("sequential command did not block");
  AST_MSS: assert property (@(posedge clk) disable iff (rst)
    stb[MSS_BIT] == |(stb & sre))
    else $error("summary bit wrong");
  AST_SRQ_MASK: assert property (@(posedge clk) disable iff (rst)
    ce && $past(ce) && |(ssr_rise(sre, $past(sre)) & stb_low) |=> srq)
    else $error("mask edge without request");
  AST_CLS_KEEP: assert property (@(posedge clk) disable iff (rst)
    ce && take && cmd.op == SSR_CMD_CLS |=> err_clear && sre == $past(sre) && ese == $past(ese))
    else $error("clear status lost or changed an enable");
  AST_OVL_FREE: assert property (@(posedge clk) disable iff (rst)
    ce && take && cmd.op == SSR_CMD_OVL |=> !idle_overlap_flag && cmd_ready)
    else $error("overlapped command blocked or not pending");
  AST_EVT_HOLD: assert property (@(posedge clk) disable iff (rst)
    ce && !(take && (cmd.op == SSR_CMD_CLS || cmd.op == SSR_CMD_ESRQ)) |=>
      ($past(esr) & ~esr) == 8'h00)
    else $error("event bit lost without clear");

endmodule
`default_nettype wire

// ---- verif/ssr_ctl_model.sv ----
// remote controller model: issues commands and counts service requests
`timescale 1ns/1ps
`default_nettype none
module ssr_ctl_model
  import ssr_pkg::*;
(
  // clocking
  input  wire logic    clk,
  // command port
  input  wire logic    cmd_ready,
  output var logic     cmd_valid,
  output var ssr_cmd_s cmd,
  // service request
  input  wire logic    srq
);
  int n_srq = 0;
  int cyc   = 0;
  bit busy  = 1'b0;

  initial begin
    cmd_valid = 1'b0;
    cmd       = '0;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (srq === 1'b1) n_srq <= n_srq + 1;
    // idle word churns so a stale command can never pass for a live one
    if (!busy && !cmd_valid) cmd <= ssr_cmd_s'(~cmd);
  end

  // request held until ready is sampled high at an edge
  task automatic send(input ssr_cmd_e op, input logic [7:0] arg, output int t);
    busy = 1'b1;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd       <= '{op: op, arg: arg};
    do @(posedge clk); while (cmd_ready !== 1'b1);
    t = cyc;
    cmd_valid <= 1'b0;
    busy = 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
// self-checking bench for the status service request core
`timescale 1ns/1ps
`default_nettype none
module testbench
  import ssr_pkg::*;
;
  localparam int SEQ_N = 4;
  localparam int OVL_N = 16;
  logic       clk          = 1'b0;
  logic       rst          = 1'b1;
  logic       ce           = 1'b1;
  logic       cmd_valid;
  ssr_cmd_s   cmd;
  logic       cmd_ready;
  ssr_resp_s  resp;
  logic [4:0] stb_src      = '0;
  logic       err_nonempty = 1'b0;
  logic [7:0] evt_set      = '0;
  logic       board_fault  = 1'b0;
  logic       err_clear;
  logic [7:0] setting;
  logic       srq;
  int         mismatches   = 0;
  int         n_compared   = 0;
  int         n_clr        = 0;
  int         t0, t1, t2, s0;
  logic [7:0] expq[$];
  logic [31:0] seed        = 32'h00000018;

  ssr_top #(.SEQ_CYC(SEQ_N), .OVL_CYC(OVL_N)) uut (
    .clk(clk), .rst(rst), .ce(ce), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready(cmd_ready), .resp(resp), .stb_src(stb_src),
    .err_nonempty(err_nonempty), .evt_set(evt_set), .board_fault(board_fault),
    .err_clear(err_clear), .setting(setting), .srq(srq)
  );

  ssr_ctl_model ctl (
    .clk(clk), .cmd_ready(cmd_ready), .cmd_valid(cmd_valid), .cmd(cmd), .srq(srq)
  );

  initial begin
    forever #2.5 clk = ~clk;
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic ask(input ssr_cmd_e op, input logic [7:0] exp);
    int t;
    expq.push_back(exp);
    ctl.send(op, 8'h00, t);
  endtask

  task automatic put(input ssr_cmd_e op, input logic [7:0] arg);
    int t;
    ctl.send(op, arg, t);
  endtask

  task automatic drain;
    for (int k = 0; k < 400 && expq.size() != 0; k++) @(posedge clk);
    repeat (2) @(posedge clk);
    check(8'(expq.size()), 8'h00);
  endtask

  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // response watcher
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (err_clear === 1'b1) n_clr++;
    if (resp.valid === 1'b1) begin
      if (expq.size() == 0) begin
        mismatches++;
        $display("BAD t=%0t unexpected answer %h", $time, resp.data);
      end else check(resp.data, expq.pop_front());
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    logic [7:0] v;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    ask(SSR_CMD_SREQ, SRE_RST);
    ask(SSR_CMD_STBQ, 8'h00);
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      v = (i == 0) ? 8'hFF : seed[7:0];
      put(SSR_CMD_SRE, v);
      ask(SSR_CMD_SREQ, v & 8'hBF);
    end
    put(SSR_CMD_SRE, 8'h00);
    @(posedge clk) begin
      stb_src      <= 5'h1F;
      err_nonempty <= 1'b1;
    end
    ask(SSR_CMD_STBQ, 8'h9F);
    ask(SSR_CMD_STBQ, 8'h9F);
    @(posedge clk) begin
      stb_src      <= 5'h00;
      err_nonempty <= 1'b0;
    end
    put(SSR_CMD_SRE, 8'h01);
    repeat (3) @(posedge clk);
    s0 = ctl.n_srq;
    @(posedge clk) stb_src <= 5'h01;
    repeat (4) @(posedge clk);
    check(8'(ctl.n_srq - s0), 8'h01);
    put(SSR_CMD_SRE, 8'h00);
    put(SSR_CMD_SRE, 8'h01);
    repeat (3) @(posedge clk);
    check(8'(ctl.n_srq - s0), 8'h02);
    ask(SSR_CMD_STBQ, 8'h41);
    put(SSR_CMD_ESE, 8'h01);
    @(posedge clk) evt_set <= 8'h01;
    @(posedge clk) evt_set <= 8'h00;
    ask(SSR_CMD_STBQ, 8'h61);
    put(SSR_CMD_SET, 8'h5A);
    repeat (2) @(posedge clk);
    check(setting, 8'h5A);
    put(SSR_CMD_RST, 8'h00);
    repeat (2) @(posedge clk);
    check(setting, SET_RST);
    ask(SSR_CMD_SREQ, 8'h01);
    ask(SSR_CMD_ESEQ, 8'h01);
    // clear status pulses the error clear, drops the event summary bit, keeps enables
    s0 = n_clr;
    put(SSR_CMD_CLS, 8'h00);
    repeat (3) @(posedge clk);
    check(8'(n_clr - s0), 8'h01);
    ask(SSR_CMD_STBQ, 8'h41);
    ask(SSR_CMD_ESEQ, 8'h01);
    ask(SSR_CMD_ESRQ, 8'h00);
    put(SSR_CMD_NOP, 8'h00);
    drain();
    board_fault <= 1'b0;
    ask(SSR_CMD_TSTQ, TST_PASS);
    drain();
    board_fault <= 1'b1;
    ask(SSR_CMD_TSTQ, 8'h01);
    drain();
    board_fault <= 1'b0;
    ctl.send(SSR_CMD_SEQ, 8'h00, t0);
    expq.push_back(8'h01);
    ctl.send(SSR_CMD_SREQ, 8'h00, t1);
    check(8'(t1 - t0 >= SEQ_N), 8'h01);
    ctl.send(SSR_CMD_OVL, 8'h00, t0);
    expq.push_back(8'h01);
    ctl.send(SSR_CMD_SREQ, 8'h00, t1);
    check(8'(t1 - t0 <= 2), 8'h01);
    put(SSR_CMD_WAI, 8'h00);
    expq.push_back(8'h01);
    ctl.send(SSR_CMD_SREQ, 8'h00, t2);
    check(8'(t2 - t0 >= OVL_N - 1), 8'h01);
    drain();
    put(SSR_CMD_OVL, 8'h00);
    ask(SSR_CMD_OPCQ, OPC_ANSWER);
    drain();
    // a pending completion query must be dropped by device reset
    put(SSR_CMD_OVL, 8'h00);
    put(SSR_CMD_OPCQ, 8'h00);
    put(SSR_CMD_RST, 8'h00);
    repeat (OVL_N + 6) @(posedge clk);
    drain();
    // frozen clock enable: a status edge waits until the enable returns
    put(SSR_CMD_SRE, 8'h02);
    s0 = ctl.n_srq;
    @(posedge clk) begin
      ce      <= 1'b0;
      stb_src <= 5'h03;
    end
    repeat (6) @(posedge clk);
    check(8'(ctl.n_srq - s0), 8'h00);
    @(posedge clk) ce <= 1'b1;
    repeat (4) @(posedge clk);
    check(8'(ctl.n_srq - s0), 8'h01);
    ask(SSR_CMD_STBQ, 8'h43);
    drain();
    give_verdict();
  end

  // hang guard, well beyond the few hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    give_verdict();
  end
endmodule
`default_nettype wire
